// ---- setf_event_filter.v ----
// What this block does
// - With event 0x5d selected, snoop replies to locally originated requests are counted through the reply-type subevent bits.
// - Local reply subevent bit 0 picks invalid replies and bit 1 picks shared non-forwarding replies.
// - Local reply subevent bit 2 picks invalidate-forward replies and bit 3 picks shared-forward replies.
// - Local reply subevent bit 4 picks both invalidate and shared writeback replies.
// - Local reply subevent bit 5 picks forward-with-writeback replies, seen only in four-socket systems.
// - Local reply subevent bit 6 picks plain conflict and conflict-with-writeback-invalidate replies.
// - Local reply subevent bit 7 picks plain forward replies, seen only for current reads.
// - With event 0x6b selected, bits 0 to 5 pick the two modified-to-invalid and four partial forward/pull replies.
// - With event 0x35 selected, qualified tracker inserts are counted, at most one per cycle, only on counters 0-3.
// - Tracker inserts that carry no address are never counted.
// - Insert qualification is the OR of chosen queue bits ANDed with the OR of chosen hit and miss bits, or with 1 if neither is chosen.
// - With opcode match set, only inserts whose opcode equals extended bits 29 to 19 count.
// - With original opcode match set, the pre-conversion opcode is compared with those bits instead.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "setf_map.vh"

module setf_event_filter (
	input wire I_CLK,
	input wire I_SYS_RST,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [11:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output wire O_PREADY,
	output wire [31:0] O_PRDATA,
	output wire O_PSLVERR,
	input wire I_SNP_VALID,
	input wire I_SNP_LOCAL,
	input wire [3:0] I_SNP_TYPE,
	input wire I_INS_VALID,
	input wire I_INS_ADDRLESS,
	input wire [5:0] I_INS_QUEUE,
	input wire I_INS_HIT,
	input wire I_INS_DDR,
	input wire I_INS_PMM,
	input wire I_INS_HBM,
	input wire I_INS_MMIO,
	input wire I_INS_MMCFG,
	input wire I_INS_LOCAL_TGT,
	input wire I_INS_NEARMEM,
	input wire I_INS_NONCOH,
	input wire I_INS_ISOC,
	input wire [10:0] I_INS_OPC,
	input wire [10:0] I_INS_ORIG_OPC,
	output wire [7:0] O_CNT_INC
);

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg [31:0] ctrl_q;
reg [31:0] xtra_q;
reg [31:0] count_q;
reg stat_blocked_q;
reg pready_q;
reg pslverr_q;
reg [31:0] prdata_q;
reg [7:0] inc_q;

wire [7:0] evt_code = ctrl_q[`SETF_CTRL_EVT_HI:`SETF_CTRL_EVT_LO];
wire [7:0] umask = ctrl_q[`SETF_CTRL_UMASK_HI:`SETF_CTRL_UMASK_LO];
wire [2:0] ctr_sel = ctrl_q[`SETF_CTRL_CTR_HI:`SETF_CTRL_CTR_LO];
wire evt_en = ctrl_q[`SETF_CTRL_EN];
wire [10:0] opc_ref = xtra_q[`SETF_X_OPC_HI:`SETF_X_OPC_LO];

// ----------------------------------------------------------------
// snoop reply decode
// ----------------------------------------------------------------
reg [7:0] local_vec;
reg [7:0] misc_vec;

always @* begin
	local_vec = 8'h00;
	misc_vec = 8'h00;
	case (I_SNP_TYPE)
	`SETF_RSP_INVALID: begin
		local_vec[0] = 1'b1;
	end
	`SETF_RSP_SHARED: begin
		local_vec[1] = 1'b1;
	end
	`SETF_RSP_INV_FWD: begin
		local_vec[2] = 1'b1;
	end
	`SETF_RSP_SHR_FWD: begin
		local_vec[3] = 1'b1;
	end
	`SETF_RSP_INV_WB, `SETF_RSP_SHR_WB: begin
		local_vec[4] = 1'b1;
	end
	`SETF_RSP_FWD_WB: begin
		local_vec[5] = 1'b1;
	end
	`SETF_RSP_CONFLICT, `SETF_RSP_CNFLCT_WBI: begin
		local_vec[6] = 1'b1;
	end
	`SETF_RSP_PLAIN_FWD: begin
		local_vec[7] = 1'b1;
	end
	`SETF_RSP_MTOI_FWDM: begin
		misc_vec[0] = 1'b1;
	end
	`SETF_RSP_MTOI_DATAM: begin
		misc_vec[1] = 1'b1;
	end
	`SETF_RSP_PTLFWD_SF: begin
		misc_vec[2] = 1'b1;
	end
	`SETF_RSP_PTLFWD_LLC: begin
		misc_vec[3] = 1'b1;
	end
	`SETF_RSP_PULLPTL_SF: begin
		misc_vec[4] = 1'b1;
	end
	`SETF_RSP_PULLPTL_LLC: begin
		misc_vec[5] = 1'b1;
	end
	default: begin
		local_vec = 8'h00;
	end
	endcase
end

// only locally originated requests feed the local event
wire local_hit = I_SNP_VALID & I_SNP_LOCAL & (|(local_vec & umask));
wire misc_hit = I_SNP_VALID & (|(misc_vec[5:0] & umask[5:0]));

// ----------------------------------------------------------------
// tracker insert qualification
// ----------------------------------------------------------------
// the queue bits must be set by software; with none set nothing counts
wire queue_ok = |(I_INS_QUEUE & umask[5:0]);

wire hm_ok;
wire tgt_ok;
wire near_ok;

// hit and miss both clear means no hit/miss filtering at all
setf_pair_sel u_hm_sel (
	.i_pick_set(xtra_q[`SETF_X_HIT]),
	.i_pick_clr(xtra_q[`SETF_X_MISS]),
	.i_attr(I_INS_HIT),
	.o_pass(hm_ok)
);

// optional groups: an empty group does not filter
wire [4:0] mem_sel = {xtra_q[`SETF_X_MMCFG], xtra_q[`SETF_X_MMIO],
	xtra_q[`SETF_X_HBM], xtra_q[`SETF_X_PMM], xtra_q[`SETF_X_DDR]};
wire [4:0] mem_req = {I_INS_MMCFG, I_INS_MMIO, I_INS_HBM, I_INS_PMM,
	I_INS_DDR};
wire mem_ok = ~(|mem_sel) | (|(mem_sel & mem_req));

setf_pair_sel u_tgt_sel (
	.i_pick_set(xtra_q[`SETF_X_LOCAL]),
	.i_pick_clr(xtra_q[`SETF_X_REMOTE]),
	.i_attr(I_INS_LOCAL_TGT),
	.o_pass(tgt_ok)
);

setf_pair_sel u_near_sel (
	.i_pick_set(xtra_q[`SETF_X_NEARMEM]),
	.i_pick_clr(xtra_q[`SETF_X_NOTNEAR]),
	.i_attr(I_INS_NEARMEM),
	.o_pass(near_ok)
);

wire nc_ok = ~xtra_q[`SETF_X_NONCOH] | I_INS_NONCOH;
wire isoc_ok = ~xtra_q[`SETF_X_ISOC] | I_INS_ISOC;

// original opcode takes precedence when both match bits are set
wire [10:0] opc_cmp = xtra_q[`SETF_X_ORIG_MATCH] ? I_INS_ORIG_OPC :
	I_INS_OPC;
wire opc_en = xtra_q[`SETF_X_OPC_MATCH] | xtra_q[`SETF_X_ORIG_MATCH];
wire opc_ok = ~opc_en | (opc_cmp == opc_ref);

wire ins_hit = I_INS_VALID & ~I_INS_ADDRLESS & queue_ok & hm_ok &
	mem_ok & tgt_ok & near_ok & nc_ok & isoc_ok & opc_ok;

// ----------------------------------------------------------------
// increment selection
// ----------------------------------------------------------------
wire ins_ctr_ok = (ctr_sel <= `SETF_INS_MAX_CTR);
reg evt_hit;

always @* begin
	case (evt_code)
	`SETF_EVT_LOCAL_SNP: begin
		evt_hit = local_hit;
	end
	`SETF_EVT_MISC_SNP: begin
		evt_hit = misc_hit;
	end
	`SETF_EVT_TRK_INS: begin
		evt_hit = ins_hit & ins_ctr_ok;
	end
	default: begin
		evt_hit = 1'b0;
	end
	endcase
end

wire inc_now = evt_en & evt_hit;
wire blocked = evt_en & (evt_code == `SETF_EVT_TRK_INS) & ~ins_ctr_ok;

// ----------------------------------------------------------------
// apb slave, one wait-free access cycle after setup
// ----------------------------------------------------------------
wire setup = I_PSEL & ~I_PENABLE & ~pready_q;
wire access = I_PSEL & I_PENABLE & pready_q;
wire wr = access & I_PWRITE;

reg [31:0] rd_mux;
reg rd_err;

always @* begin
	rd_err = 1'b0;
	case (I_PADDR)
	`SETF_OFS_CTRL: begin
		rd_mux = ctrl_q;
	end
	`SETF_OFS_XTRA: begin
		rd_mux = xtra_q;
	end
	`SETF_OFS_COUNT: begin
		rd_mux = count_q;
	end
	`SETF_OFS_STAT: begin
		rd_mux = {31'h0, stat_blocked_q};
	end
	default: begin
		rd_mux = 32'h00000000;
		rd_err = 1'b1;
	end
	endcase
end

always @(posedge I_CLK) begin
	if (I_SYS_RST) begin
		pready_q <= 1'b0;
		pslverr_q <= 1'b0;
		prdata_q <= 32'h00000000;
	end else begin
		pready_q <= setup;
		pslverr_q <= setup & rd_err;
		if (setup & ~I_PWRITE) begin
			prdata_q <= rd_mux;
		end
	end
end

// ----------------------------------------------------------------
// configuration, tally and increment output
// ----------------------------------------------------------------
always @(posedge I_CLK) begin
	if (I_SYS_RST) begin
		ctrl_q <= `SETF_CTRL_RST;
		xtra_q <= `SETF_XTRA_RST;
		count_q <= 32'h00000000;
		stat_blocked_q <= 1'b0;
		inc_q <= 8'h00;
	end else begin
		if (wr & (I_PADDR == `SETF_OFS_CTRL)) begin
			ctrl_q <= I_PWDATA;
		end
		if (wr & (I_PADDR == `SETF_OFS_XTRA)) begin
			xtra_q <= I_PWDATA;
		end
		// a same-cycle increment is counted on top of the software clear, leaving the tally at 1
		if (inc_now) begin
			if (wr & (I_PADDR == `SETF_OFS_COUNT)) begin
				count_q <= 32'h00000001;
			end else begin
				count_q <= count_q + 32'h00000001;
			end
		end else if (wr & (I_PADDR == `SETF_OFS_COUNT)) begin
			count_q <= 32'h00000000;
		end
		stat_blocked_q <= blocked;
		// one pulse per cycle at most, routed to the chosen counter
		inc_q <= inc_now ? (8'h01 << ctr_sel) : 8'h00;
	end
end

assign O_PREADY = pready_q;
assign O_PRDATA = prdata_q;
assign O_PSLVERR = pslverr_q;
assign O_CNT_INC = inc_q;

endmodule // setf_event_filter

// ----------------------------------------------------------------
// two-way qualifier pair
// ----------------------------------------------------------------
module setf_pair_sel (
	input wire i_pick_set,
	input wire i_pick_clr,
	input wire i_attr,
	output wire o_pass
);

// an empty pair leaves the group open so other filters stay usable alone
assign o_pass = ~(i_pick_set | i_pick_clr) | (i_pick_set & i_attr) |
	(i_pick_clr & ~i_attr);

endmodule // setf_pair_sel

// ---- setf_map.vh ----
`ifndef SETF_MAP_VH
`define SETF_MAP_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SETF_OFS_CTRL 12'h000
`define SETF_OFS_XTRA 12'h004
`define SETF_OFS_COUNT 12'h008
`define SETF_OFS_STAT 12'h00c

// ----------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------
`define SETF_CTRL_EVT_HI 7
`define SETF_CTRL_EVT_LO 0
`define SETF_CTRL_UMASK_HI 15
`define SETF_CTRL_UMASK_LO 8
`define SETF_CTRL_CTR_HI 18
`define SETF_CTRL_CTR_LO 16
`define SETF_CTRL_EN 22
`define SETF_CTRL_RST 32'h00000000
`define SETF_XTRA_RST 32'h00000000

// ----------------------------------------------------------------
// event codes
// ----------------------------------------------------------------
`define SETF_EVT_LOCAL_SNP 8'h5d
`define SETF_EVT_MISC_SNP 8'h6b
`define SETF_EVT_TRK_INS 8'h35
`define SETF_INS_MAX_CTR 3'h3

// ----------------------------------------------------------------
// extended qualifier fields
// ----------------------------------------------------------------
`define SETF_X_HIT 0
`define SETF_X_MISS 1
`define SETF_X_DDR 2
`define SETF_X_PMM 3
`define SETF_X_HBM 4
`define SETF_X_MMIO 5
`define SETF_X_MMCFG 6
`define SETF_X_LOCAL 7
`define SETF_X_REMOTE 8
`define SETF_X_NEARMEM 10
`define SETF_X_NOTNEAR 11
`define SETF_X_NONCOH 12
`define SETF_X_ISOC 13
`define SETF_X_OPC_MATCH 17
`define SETF_X_ORIG_MATCH 18
`define SETF_X_OPC_HI 29
`define SETF_X_OPC_LO 19

// ----------------------------------------------------------------
// snoop reply type codes on the pipeline port
// ----------------------------------------------------------------
`define SETF_RSP_INVALID 4'h0
`define SETF_RSP_SHARED 4'h1
`define SETF_RSP_INV_FWD 4'h2
`define SETF_RSP_SHR_FWD 4'h3
`define SETF_RSP_INV_WB 4'h4
`define SETF_RSP_SHR_WB 4'h5
`define SETF_RSP_FWD_WB 4'h6
`define SETF_RSP_CONFLICT 4'h7
`define SETF_RSP_CNFLCT_WBI 4'h8
`define SETF_RSP_PLAIN_FWD 4'h9
`define SETF_RSP_MTOI_FWDM 4'ha
`define SETF_RSP_MTOI_DATAM 4'hb
`define SETF_RSP_PTLFWD_SF 4'hc
`define SETF_RSP_PTLFWD_LLC 4'hd
`define SETF_RSP_PULLPTL_SF 4'he
`define SETF_RSP_PULLPTL_LLC 4'hf

`endif

// ---- setf_event_filter_sva.sv ----
`timescale 1ns/1ps
module setf_chk (
	input wire I_CLK,
	input wire I_SYS_RST,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire O_PREADY,
	input wire O_PSLVERR,
	input wire I_SNP_VALID,
	input wire I_SNP_LOCAL,
	input wire [3:0] I_SNP_TYPE,
	input wire I_INS_VALID,
	input wire I_INS_ADDRLESS,
	input wire [7:0] O_CNT_INC
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);
	a_ready_one: assert property (O_PREADY |=> !O_PREADY) else $error("ready");
	a_ready_setup: assert property (I_PSEL && !I_PENABLE && !O_PREADY
		|=> O_PREADY) else $error("no ready");
	a_err_ready: assert property (O_PSLVERR |-> O_PREADY) else $error("err");
	a_inc_onehot: assert property ($onehot0(O_CNT_INC)) else $error("inc");
	a_inc_cause: assert property (O_CNT_INC != 8'h00
		|-> $past(I_SNP_VALID || I_INS_VALID)) else $error("cause");
	a_no_addr: assert property (I_INS_VALID && I_INS_ADDRLESS && !I_SNP_VALID
		|=> O_CNT_INC == 8'h00) else $error("addrless");
	a_remote_skip: assert property (I_SNP_VALID && !I_SNP_LOCAL
		&& I_SNP_TYPE < 4'ha && !I_INS_VALID |=> O_CNT_INC == 8'h00)
		else $error("remote");
	a_high_ctr: assert property (O_CNT_INC[7:4] != 4'h0
		|-> $past(I_SNP_VALID)) else $error("high ctr");
	cover property (O_PSLVERR);
	cover property (O_CNT_INC[7]);
	cover property (I_INS_VALID ##1 O_CNT_INC != 8'h00);
endmodule // setf_chk
bind setf_event_filter setf_chk u_chk (.I_CLK, .I_SYS_RST, .I_PSEL,
	.I_PENABLE, .O_PREADY, .O_PSLVERR, .I_SNP_VALID, .I_SNP_LOCAL,
	.I_SNP_TYPE, .I_INS_VALID, .I_INS_ADDRLESS, .O_CNT_INC);

// ---- setf_pipe_model.sv ----
`timescale 1ns/1ps
module setf_pipe_model (
	input wire clk,
	output reg snp_valid = 1'b0,
	output reg snp_local = 1'b0,
	output reg [3:0] snp_type = 4'h0,
	output reg ins_valid = 1'b0,
	output reg ins_addrless = 1'b0,
	output reg [5:0] ins_queue = 6'h00,
	output reg ins_hit = 1'b0,
	output reg [8:0] ins_misc = 9'h000,
	output reg [10:0] ins_opc = 11'h000,
	output reg [10:0] ins_orig = 11'h000
);
	// one reply and one insert per call; local, type, queue and opcodes invert once valid drops, while hit, addrless and misc hold
	task send(input sv, input sl, input [3:0] st, input iv, input ia,
		input [5:0] q, input h, input [10:0] o, input [10:0] g, input int gap);
		begin
			repeat (gap) @(posedge clk);
			@(posedge clk);
			{snp_valid, snp_local, snp_type, ins_valid} <= {sv, sl, st, iv};
			{ins_addrless, ins_queue, ins_hit, ins_opc, ins_orig} <= {ia, q, h, o, g};
			ins_misc <= 9'($urandom);
			@(posedge clk);
			{snp_valid, ins_valid} <= 2'b00;
			{snp_local, snp_type, ins_queue, ins_opc, ins_orig} <=
				~{snp_local, snp_type, ins_queue, ins_opc, ins_orig};
		end
	endtask
endmodule // setf_pipe_model

// ---- setf_event_filter_tb.sv ----
`timescale 1ns/1ps
module setf_event_filter_tb;
	reg I_CLK = 1'b0;
	reg I_SYS_RST = 1'b1;
	reg I_PSEL = 1'b0;
	reg I_PENABLE = 1'b0;
	reg I_PWRITE = 1'b0;
	reg [11:0] I_PADDR = 12'h000;
	reg [31:0] I_PWDATA = 32'h00000000;
	wire O_PREADY, O_PSLVERR, sv, sl, iv, ia, ih;
	wire [31:0] O_PRDATA;
	wire [7:0] O_CNT_INC;
	wire [3:0] st;
	wire [5:0] iq;
	wire [8:0] im;
	wire [10:0] io, ig;
	int err_total = 0;
	int num_checks = 0;
	int exp_cnt = 0;
	int cyc = 0;
	int loc_bit[16] = '{0, 1, 2, 3, 4, 4, 5, 6, 6, 7, -1, -1, -1, -1, -1, -1};
	logic [7:0] ev, um, evs[4] = '{8'h5d, 8'h6b, 8'h35, 8'h11};
	logic [31:0] xt, r;
	logic [10:0] o, g;
	logic [5:0] q;
	logic [3:0] s_t;
	logic [2:0] ctr;
	logic en, e, s_v, s_l, i_v, i_a, h;

	setf_pipe_model u_pipe (.clk(I_CLK), .snp_valid(sv), .snp_local(sl),
		.snp_type(st), .ins_valid(iv), .ins_addrless(ia), .ins_queue(iq),
		.ins_hit(ih), .ins_misc(im), .ins_opc(io), .ins_orig(ig));
	setf_event_filter u_dut (.I_CLK, .I_SYS_RST, .I_PSEL, .I_PENABLE,
		.I_PWRITE, .I_PADDR, .I_PWDATA, .O_PREADY, .O_PRDATA, .O_PSLVERR,
		.I_SNP_VALID(sv), .I_SNP_LOCAL(sl), .I_SNP_TYPE(st), .I_INS_VALID(iv),
		.I_INS_ADDRLESS(ia), .I_INS_QUEUE(iq), .I_INS_HIT(ih),
		.I_INS_DDR(im[0]), .I_INS_PMM(im[1]), .I_INS_HBM(im[2]),
		.I_INS_MMIO(im[3]), .I_INS_MMCFG(im[4]), .I_INS_LOCAL_TGT(im[5]),
		.I_INS_NEARMEM(im[6]), .I_INS_NONCOH(im[7]), .I_INS_ISOC(im[8]),
		.I_INS_OPC(io), .I_INS_ORIG_OPC(ig), .O_CNT_INC);

	// -------------------------------------------------------------
	// reference model and bench tasks
	// -------------------------------------------------------------
	function logic [7:0] model();
		logic hit;
		hit = 1'b0;
		if (ev == 8'h5d && s_v && s_l && loc_bit[s_t] >= 0)
			hit = um[loc_bit[s_t]];
		if (ev == 8'h6b && s_v && s_t >= 4'ha)
			hit = um[s_t - 4'ha];
		if (ev == 8'h35 && ctr < 3'h4 && i_v && !i_a)
			hit = (|(um[5:0] & q)) && (xt[1:0] == 2'b00 || xt[h ? 0 : 1])
				&& (xt[6:2] == 5'h00 || |(xt[6:2] & im[4:0]))
				&& (xt[8:7] == 2'b00 || xt[im[5] ? 7 : 8]) && (!xt[12] || im[7])
				&& (xt[11:10] == 2'b00 || xt[im[6] ? 10 : 11]) && (!xt[13] || im[8])
				&& (xt[18] ? g == xt[29:19] : (!xt[17] || o == xt[29:19]));
		return (en && hit) ? 8'h01 << ctr : 8'h00;
	endfunction
	task chk(input string name, input [31:0] seen, input [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task close_out;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge I_CLK);
		{I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} <= {2'b10, w, a, d};
		@(posedge I_CLK);
		I_PENABLE <= 1'b1;
		do @(posedge I_CLK); while (O_PREADY !== 1'b1);
		r = O_PRDATA;
		e = O_PSLVERR;
		{I_PSEL, I_PENABLE} <= 2'b00;
	endtask

	initial begin
		forever #4 I_CLK = ~I_CLK;
	end
	always @(posedge I_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		void'($urandom(6235));
		repeat (8) @(posedge I_CLK);
		I_SYS_RST <= 1'b0;
		apb(0, 12'h000, 0);
		chk("ctrl", r, 0);
		apb(0, 12'h010, 0);
		chk("slverr", {31'h0, e}, 1);
		chk("rdata", r, 0);
		for (int n = 0; n < 600; n++) begin
			{ev, um, ctr, en} = {evs[$urandom % 4], 8'($urandom), 3'($urandom), 1'($urandom % 4 != 0)};
			xt = {11'h000, 2'($urandom), 2'($urandom), 3'h0,
				12'($urandom & $urandom & $urandom & $urandom), 2'($urandom)};
			if (xt[1:0] != 2'b00 && um[5:0] == 6'h00) um[0] = 1'b1;
			{s_v, s_l, s_t, i_v, i_a, h} = {2'($urandom), 4'($urandom), 1'($urandom), $urandom % 4 == 0, 1'($urandom)};
			{q, o, g} = {6'h01 << ($urandom % 6), 11'($urandom % 4), 11'($urandom % 4)};
			apb(1, 12'h000, {9'h000, en, 3'h0, ctr, um, ev});
			apb(1, 12'h004, xt);
			u_pipe.send(s_v, s_l, s_t, i_v, i_a, q, h, o, g, $urandom % 3);
			#1 r = {24'h000000, model()};
			exp_cnt += (r != 0);
			chk("inc", {24'h0, O_CNT_INC}, r);
		end
		apb(0, 12'h004, 0);
		chk("xtra", r, xt);
		apb(0, 12'h00c, 0);
		chk("blocked", r, {31'h0, en && ev == 8'h35 && ctr > 3'h3});
		apb(0, 12'h008, 0);
		chk("count", r, exp_cnt);
		apb(1, 12'h008, 0);
		apb(0, 12'h008, 0);
		chk("cleared", r, 0);
		close_out();
	end
endmodule // setf_event_filter_tb
